//--- hw/gate_drive_fault_sequencer.sv
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - mosfet mode: high phase to positive supply
// - jfet mode: high phase to source reference
// - pwm rising edge asserts pull-up
// - clamp released with pull-up, same cycle
// - pwm falling edge drives pull-down low
// - clamp asserted after clamp delay
// - undervoltage clears fault flag, starts timer
// - pwm ignored during hold time
// - pull-down held active during hold time
// - undervoltage persisting after hold: wait clear
// - sample saturation after blanking; low passes
// - high saturation sample raises fault, timer
// - saturation persisting after hold: restart timer
// - no fault at hold end: resume
// - resume only on next pwm rising edge
// - undervoltage, power-good, saturation share timer
// - hold time 0.5 us per pF, bounded
// - power-up waits supplies, then hold timer
module gate_drive_fault_sequencer
    import gate_drive_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int HOLD_W = 32,
    parameter logic [PF_W-1:0] FAULT_CAP_RESET_PF = FAULT_CAP_RESET
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire logic pwm_in,
    input wire logic undervoltage_lockout,
    input wire logic power_good,
    input wire logic saturation_sense_input,
    output logic pull_up_output,
    output logic pull_down_output_n,
    output logic miller_clamp_drive,
    output logic gate_high_to_source_ref,
    output logic fault_n
);

    localparam logic [CNT_W-1:0] CLAMP_RESET = CNT_W'(CLAMP_DELAY_CYCLES);
    localparam logic [CNT_W-1:0] BLANK_RESET = CNT_W'(BLANK_TIME_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_PER_PF = HOLD_W'(HOLD_CYCLES_PER_PF);

    if (CNT_W < 8 || CNT_W > 32) begin : g_cnt_check
        $error("CNT_W must lie between 8 and 32");
    end
    if (HOLD_W < 26 || HOLD_W > 32) begin : g_hold_check
        $error("HOLD_W must lie between 26 and 32 to hold 500 ms");
    end
    if (FAULT_CAP_RESET_PF < HOLD_MIN_PF || FAULT_CAP_RESET_PF > HOLD_MAX_PF) begin : g_pf_check
        $error("FAULT_CAP_RESET_PF outside the supported hold range");
    end
    // reset delay counts must fit the counters they load
    if (64'(CLAMP_DELAY_CYCLES) >= (64'd1 << CNT_W)
            || 64'(BLANK_TIME_CYCLES) >= (64'd1 << CNT_W)) begin : g_reset_fit
        $error("delay reset counts do not fit CNT_W");
    end

    typedef struct packed {
        seq_state_t fsm;
        logic fault_sat;
        logic pwm_prev;
        logic gate_on;
        logic blank_run;
        logic [CNT_W-1:0] blank_cnt;
        logic [CNT_W-1:0] clamp_cnt;
        logic [HOLD_W-1:0] hold_cnt;
        logic [HOLD_W-1:0] hold_limit;
        logic jfet_mode;
        logic [CNT_W-1:0] clamp_cycles;
        logic [CNT_W-1:0] blank_cycles;
        logic [PF_W-1:0] fault_cap_pf;
        logic [15:0] fault_count;
        logic pull_up;
        logic pull_down_n;
        logic clamp;
        logic src_ref;
        logic fault_n;
        apb_rsp_t rsp;
    } seq_t;

    seq_t q;
    seq_t d;

    logic [3:0] sense_raw;
    logic [3:0] sense_s;
    logic pwm_s;
    logic uv_s;
    logic pg_s;
    logic sat_s;

    assign sense_raw = {saturation_sense_input, power_good, undervoltage_lockout, pwm_in};

    sense_sync #(
        .WIDTH(4)
    ) u_sense_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(sense_raw),
        .sync_out(sense_s)
    );

    assign pwm_s = sense_s[0];
    assign uv_s = sense_s[1];
    assign pg_s = sense_s[2];
    assign sat_s = sense_s[3];

    logic rise;
    logic fall;
    logic supply_bad;
    logic hold_done;
    logic [HOLD_W-1:0] hold_cycles;
    logic setup_phase;
    logic wr_en;
    logic [31:0] status_word;
    logic [PF_W-1:0] pf_in;

    always_comb begin
        d = q;
        rise = pwm_s & ~q.pwm_prev;
        fall = ~pwm_s & q.pwm_prev;
        // any supply problem counts as the undervoltage class of fault
        supply_bad = uv_s | ~pg_s;
        hold_cycles = HOLD_W'(q.fault_cap_pf) * HOLD_PER_PF;
        // limit frozen for the whole hold so a rewrite cannot shorten or wrap it
        hold_done = (q.hold_cnt >= q.hold_limit - HOLD_W'(1));
        setup_phase = apb_req.psel & ~apb_req.penable;
        wr_en = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
        pf_in = apb_req.pwdata[PF_W-1:0];
        status_word = '0;
        status_word[STATUS_STATE_LSB +: 3] = q.fsm;
        status_word[STATUS_FAULT_N_BIT] = q.fault_n;
        status_word[STATUS_SAT_TYPE_BIT] = q.fault_sat;
        status_word[STATUS_UV_BIT] = uv_s;
        status_word[STATUS_PG_BIT] = pg_s;
        status_word[STATUS_SAT_BIT] = sat_s;
        status_word[STATUS_PWM_BIT] = pwm_s;
        status_word[STATUS_GATE_ON_BIT] = q.gate_on;

        d.pwm_prev = pwm_s;
        if (q.fsm != ST_HOLD || hold_done) begin
            d.hold_limit = hold_cycles;
        end

        // apb: zero-wait answer, ready in the access phase
        d.rsp.pready = setup_phase;
        d.rsp.pslverr = 1'b0;
        d.rsp.prdata = '0;
        if (setup_phase) begin
            case (apb_req.paddr)
                CTRL_OFFSET: begin
                    d.rsp.prdata[CTRL_JFET_BIT] = q.jfet_mode;
                end
                CLAMP_DELAY_OFFSET: begin
                    d.rsp.prdata[CNT_W-1:0] = q.clamp_cycles;
                end
                BLANK_TIME_OFFSET: begin
                    d.rsp.prdata[CNT_W-1:0] = q.blank_cycles;
                end
                FAULT_CAP_OFFSET: begin
                    d.rsp.prdata[PF_W-1:0] = q.fault_cap_pf;
                end
                STATUS_OFFSET: begin
                    d.rsp.prdata = status_word;
                end
                FAULT_COUNT_OFFSET: begin
                    d.rsp.prdata[15:0] = q.fault_count;
                end
                default: begin
                    d.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_en) begin
            case (apb_req.paddr)
                CTRL_OFFSET: begin
                    d.jfet_mode = apb_req.pwdata[CTRL_JFET_BIT];
                end
                CLAMP_DELAY_OFFSET: begin
                    d.clamp_cycles = apb_req.pwdata[CNT_W-1:0];
                end
                BLANK_TIME_OFFSET: begin
                    d.blank_cycles = apb_req.pwdata[CNT_W-1:0];
                end
                FAULT_CAP_OFFSET: begin
                    // clamp to the supported 10 us .. 500 ms range
                    if (pf_in < HOLD_MIN_PF) begin
                        d.fault_cap_pf = HOLD_MIN_PF;
                    end else if (pf_in > HOLD_MAX_PF) begin
                        d.fault_cap_pf = HOLD_MAX_PF;
                    end else begin
                        d.fault_cap_pf = pf_in;
                    end
                end
                default: begin
                end
            endcase
        end

        // sequencer
        case (q.fsm)
            ST_POWERUP: begin
                d.gate_on = 1'b0;
                if (!supply_bad) begin
                    d.fsm = ST_HOLD;
                    d.hold_cnt = '0;
                    d.fault_sat = 1'b0;
                end
            end
            ST_HOLD: begin
                // pwm edges are not looked at here
                d.gate_on = 1'b0;
                d.hold_cnt = q.hold_cnt + HOLD_W'(1);
                if (supply_bad) begin
                    d.fault_sat = 1'b0;
                end
                if (hold_done) begin
                    d.hold_cnt = '0;
                    if (supply_bad) begin
                        d.fsm = ST_WAIT_CLEAR;
                    end else if (q.fault_sat && sat_s) begin
                        d.fsm = ST_HOLD;
                    end else begin
                        d.fsm = ST_ARM;
                    end
                end
            end
            ST_WAIT_CLEAR: begin
                d.gate_on = 1'b0;
                if (!supply_bad) begin
                    d.fsm = ST_ARM;
                end
            end
            ST_ARM: begin
                d.gate_on = 1'b0;
                if (supply_bad) begin
                    d.fsm = ST_HOLD;
                    d.hold_cnt = '0;
                    d.fault_sat = 1'b0;
                    d.fault_count = q.fault_count + 16'h0001;
                end else if (rise) begin
                    // a pwm already high when arming is skipped
                    d.fsm = ST_RUN;
                    d.gate_on = 1'b1;
                    d.blank_run = 1'b1;
                    d.blank_cnt = q.blank_cycles;
                end
            end
            ST_RUN: begin
                if (supply_bad) begin
                    d.fsm = ST_HOLD;
                    d.hold_cnt = '0;
                    d.fault_sat = 1'b0;
                    d.gate_on = 1'b0;
                    d.blank_run = 1'b0;
                    d.fault_count = q.fault_count + 16'h0001;
                end else if (rise) begin
                    d.gate_on = 1'b1;
                    d.blank_run = 1'b1;
                    d.blank_cnt = q.blank_cycles;
                end else if (fall) begin
                    d.gate_on = 1'b0;
                    d.blank_run = 1'b0;
                end else if (q.blank_run) begin
                    if (q.blank_cnt == '0) begin
                        d.blank_run = 1'b0;
                        if (sat_s) begin
                            d.fsm = ST_HOLD;
                            d.hold_cnt = '0;
                            d.fault_sat = 1'b1;
                            d.gate_on = 1'b0;
                            d.fault_count = q.fault_count + 16'h0001;
                        end
                    end else begin
                        d.blank_cnt = q.blank_cnt - CNT_W'(1);
                    end
                end
            end
            default: begin
                d.fsm = ST_POWERUP;
                d.gate_on = 1'b0;
            end
        endcase

        if (d.fsm != ST_RUN) begin
            d.blank_run = 1'b0;
        end

        // clamp engages only after the gate has been low for the delay
        if (d.gate_on) begin
            d.clamp = 1'b0;
            d.clamp_cnt = q.clamp_cycles;
        end else if (q.clamp_cnt == '0) begin
            d.clamp = 1'b1;
        end else begin
            d.clamp_cnt = q.clamp_cnt - CNT_W'(1);
        end

        // both stages come from one bit, so they never overlap
        d.pull_up = d.gate_on;
        d.pull_down_n = d.gate_on;
        d.src_ref = q.jfet_mode;
        d.fault_n = (d.fsm == ST_ARM) || (d.fsm == ST_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.fsm <= ST_POWERUP;
            q.jfet_mode <= CTRL_JFET_RESET;
            q.clamp_cycles <= CLAMP_RESET;
            q.blank_cycles <= BLANK_RESET;
            q.fault_cap_pf <= FAULT_CAP_RESET_PF;
            q.clamp <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp = q.rsp;
    assign pull_up_output = q.pull_up;
    assign pull_down_output_n = q.pull_down_n;
    assign miller_clamp_drive = q.clamp;
    assign gate_high_to_source_ref = q.src_ref;
    assign fault_n = q.fault_n;

endmodule

//--- hw/gate_drive_pkg.sv
package gate_drive_pkg;

    // clock and timing figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLAMP_DELAY_NS = 300;
    localparam int CLAMP_DELAY_CYCLES = (CLAMP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_TIME_NS = 1000;
    localparam int BLANK_TIME_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // hold time is 0.5 us per pF of timer capacitance
    localparam int HOLD_NS_PER_PF = 500;
    localparam int HOLD_CYCLES_PER_PF = HOLD_NS_PER_PF / CLK_PERIOD_NS;
    localparam int HOLD_MIN_NS = 10000;
    localparam int HOLD_MAX_NS = 500000000;

    localparam int PF_W = 20;
    localparam logic [PF_W-1:0] HOLD_MIN_PF = PF_W'(HOLD_MIN_NS / HOLD_NS_PER_PF);
    localparam logic [PF_W-1:0] HOLD_MAX_PF = PF_W'(HOLD_MAX_NS / HOLD_NS_PER_PF);

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] CLAMP_DELAY_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] BLANK_TIME_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] FAULT_CAP_OFFSET = 8'h0c;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] FAULT_COUNT_OFFSET = 8'h14;

    // field positions
    localparam int CTRL_JFET_BIT = 0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_FAULT_N_BIT = 3;
    localparam int STATUS_SAT_TYPE_BIT = 4;
    localparam int STATUS_UV_BIT = 5;
    localparam int STATUS_PG_BIT = 6;
    localparam int STATUS_SAT_BIT = 7;
    localparam int STATUS_PWM_BIT = 8;
    localparam int STATUS_GATE_ON_BIT = 9;

    // reset values
    localparam logic CTRL_JFET_RESET = 1'b0;
    localparam logic [PF_W-1:0] FAULT_CAP_RESET = HOLD_MIN_PF;

    typedef enum logic [2:0] {
        ST_POWERUP = 3'b000,
        ST_HOLD = 3'b001,
        ST_WAIT_CLEAR = 3'b010,
        ST_ARM = 3'b011,
        ST_RUN = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

//--- hw/sense_sync.sv
`timescale 1ns/10ps
// three-stage input synchroniser; a change is accepted once stages two and three agree
module sense_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    if (WIDTH < 1) begin : g_width_check
        $error("sense_sync needs WIDTH of at least 1");
    end

    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.out[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.out;

endmodule

//--- verification/gate_load_model.sv
`timescale 1ns/10ps
module gate_load_model (
    input wire logic pull_up_output,
    input wire logic pull_down_output_n,
    input wire logic miller_clamp_drive,
    input wire logic gate_high_to_source_ref,
    input wire logic desat_cmd,
    output logic [1:0] gate_level,
    output logic saturation_sense_input
);
    // 2 positive supply, 1 source reference, 0 negative supply, 3 contention
    // a clamp left on against a charging gate is contention as well
    always_comb begin
        if (pull_up_output && (!pull_down_output_n || miller_clamp_drive)) gate_level = 2'h3;
        else if (pull_up_output) gate_level = gate_high_to_source_ref ? 2'h1 : 2'h2;
        else gate_level = 2'h0;
    end
    // a shorted load keeps the sense node high whatever the gate does
    assign saturation_sense_input = desat_cmd;
endmodule

//--- verification/gate_drive_sva.sv
`timescale 1ns/10ps
module gate_drive_sva
    import gate_drive_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic pwm_in,
    input wire logic undervoltage_lockout,
    input wire logic pull_up_output,
    input wire logic pull_down_output_n,
    input wire logic miller_clamp_drive,
    input wire logic fault_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [10:0] low_cnt_q;
    logic [10:0] low_cnt_d;
    // saturates so a long fault cannot wrap
    always_comb begin
        low_cnt_d = low_cnt_q;
        if (fault_n) low_cnt_d = '0;
        else if (low_cnt_q != 11'h7ff) low_cnt_d = low_cnt_q + 11'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt_q <= '0;
        else low_cnt_q <= low_cnt_d;
    end
    property p_no_overlap; pull_up_output |-> pull_down_output_n; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gate charge and discharge");
    property p_clamp_release; $rose(pull_up_output) |-> !miller_clamp_drive; endproperty
    a_clamp_release: assert property (p_clamp_release) else $error("clamp not released");
    property p_clamp_wait;
        $fell(pull_up_output) |-> !miller_clamp_drive ##[1:300] (miller_clamp_drive || pull_up_output);
    endproperty
    a_clamp_wait: assert property (p_clamp_wait) else $error("clamp timing wrong");
    property p_rise_on; $rose(pwm_in) ##1 (pwm_in && fault_n)[*8] |-> pull_up_output; endproperty
    a_rise_on: assert property (p_rise_on) else $error("pull-up missing");
    property p_fall_off;
        $fell(pwm_in) ##1 (!pwm_in)[*8] |-> !pull_up_output && !pull_down_output_n;
    endproperty
    a_fall_off: assert property (p_fall_off) else $error("pull-down missing");
    property p_fault_off; !fault_n |-> !pull_up_output; endproperty
    a_fault_off: assert property (p_fault_off) else $error("gate on in fault");
    property p_uv_fault; undervoltage_lockout[*8] |-> !fault_n; endproperty
    a_uv_fault: assert property (p_uv_fault) else $error("undervoltage not flagged");
    property p_hold_min; $rose(fault_n) |-> low_cnt_q >= 11'd1000; endproperty
    a_hold_min: assert property (p_hold_min) else $error("hold time too short");
    property p_apb_ready; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready");
    property p_apb_err;
        apb_req.psel && !apb_req.penable && apb_req.paddr > 8'h14 |=> apb_rsp.pslverr;
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("no error on unmapped");
    c_fault: cover property ($fell(fault_n) && !undervoltage_lockout);
    c_pulse: cover property ($fell(pull_up_output));
    c_resume: cover property ($rose(fault_n));
endmodule
bind gate_drive_fault_sequencer gate_drive_sva i_gate_drive_sva (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pwm_in(pwm_in),
    .undervoltage_lockout(undervoltage_lockout), .pull_up_output(pull_up_output),
    .pull_down_output_n(pull_down_output_n), .miller_clamp_drive(miller_clamp_drive),
    .fault_n(fault_n));

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench
    import gate_drive_pkg::*;
;
    localparam logic [31:0] CLAMP_SET = 32'h5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic pwm = 1'b0;
    logic uv = 1'b0;
    logic pg = 1'b1;
    logic desat = 1'b0;
    logic sense, pu, pdn, clamp, src_ref, fault_n;
    logic [1:0] level;
    int miscompares = 0;
    int checks = 0;
    always #5 pclk = ~pclk;
    gate_drive_fault_sequencer i_gate_drive_fault_sequencer (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .pwm_in(pwm), .undervoltage_lockout(uv), .power_good(pg),
        .saturation_sense_input(sense), .pull_up_output(pu), .pull_down_output_n(pdn),
        .miller_clamp_drive(clamp), .gate_high_to_source_ref(src_ref), .fault_n(fault_n));
    gate_load_model i_gate_load_model (.pull_up_output(pu), .pull_down_output_n(pdn),
        .miller_clamp_drive(clamp), .gate_high_to_source_ref(src_ref), .desat_cmd(desat),
        .gate_level(level), .saturation_sense_input(sense));
    function automatic logic [1:0] exp_level(input logic on, input logic jf);
        return on ? (jf ? 2'h1 : 2'h2) : 2'h0;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic set_pwm(input logic v, input int n);
        @(posedge pclk);
        pwm <= v;
        cyc(n);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) miscompares++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wait_sig(input logic v, input int lim, ref logic s, output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        cyc(60000);
        miscompares++;
        complete_run();
    end
    initial begin
        int n;
        logic jf;
        logic [31:0] rd;
        logic err;
        n = $urandom(32'h797e);
        cyc(5);
        check("fault_n_rst", fault_n, 1'b0);
        check("pull_up_rst", pu, 1'b0);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFFSET, '0, rd, err);
        check("ctrl_rst", rd, 32'h0);
        apb(1'b1, FAULT_CAP_OFFSET, 32'h5, rd, err);
        apb(1'b0, FAULT_CAP_OFFSET, '0, rd, err);
        check("cap_floor", rd, 32'(HOLD_MIN_PF));
        apb(1'b1, CLAMP_DELAY_OFFSET, CLAMP_SET, rd, err);
        apb(1'b1, BLANK_TIME_OFFSET, 32'h14, rd, err);
        apb(1'b0, CLAMP_DELAY_OFFSET, '0, rd, err);
        check("clamp_reg", rd, CLAMP_SET);
        apb(1'b0, 8'h40, '0, rd, err);
        check("unmapped_err", err, 1'b1);
        wait_sig(1'b1, 1500, fault_n, n);
        apb(1'b0, STATUS_OFFSET, '0, rd, err);
        check("powerup_arm", rd[2:0], 3'h3);
        $display("test registers and power-up done");
        for (int i = 0; i < 8; i++) begin
            // first two passes pin both modes, the rest are random
            jf = (i < 2) ? 1'(i) : 1'($urandom_range(1));
            apb(1'b1, CTRL_OFFSET, {31'h0, jf}, rd, err);
            set_pwm(1'b1, 30 + $urandom_range(30));
            check("pu_on", pu, 1'b1);
            check("no_sat", fault_n, 1'b1);
            check("clamp_off", clamp, 1'b0);
            check("level_on", level, exp_level(1'b1, jf));
            set_pwm(1'b0, 0);
            wait_sig(1'b0, 20, pu, n);
            check("pd_on", pdn, 1'b0);
            wait_sig(1'b1, 50, clamp, n);
            check("clamp_delay", n, CLAMP_SET);
        end
        $display("test switching done");
        desat <= 1'b1;
        set_pwm(1'b1, 60);
        check("sat_fault", fault_n, 1'b0);
        check("sat_gate_off", pu, 1'b0);
        set_pwm(1'b0, 40);
        set_pwm(1'b1, 40);
        check("pwm_blanked", pu, 1'b0);
        cyc(1000);
        check("sat_restart", fault_n, 1'b0);
        desat <= 1'b0;
        wait_sig(1'b1, 1200, fault_n, n);
        check("sat_resume", fault_n, 1'b1);
        cyc(20);
        check("mid_high", pu, 1'b0);
        set_pwm(1'b0, 20);
        set_pwm(1'b1, 20);
        check("next_rise", pu, 1'b1);
        set_pwm(1'b0, 20);
        $display("test saturation done");
        uv <= 1'b1;
        cyc(10);
        check("uv_fault", fault_n, 1'b0);
        cyc(1500);
        apb(1'b0, STATUS_OFFSET, '0, rd, err);
        check("uv_wait", rd[2:0], 3'h2);
        uv <= 1'b0;
        wait_sig(1'b1, 20, fault_n, n);
        check("uv_clear", fault_n, 1'b1);
        pg <= 1'b0;
        cyc(10);
        check("pg_fault", fault_n, 1'b0);
        pg <= 1'b1;
        wait_sig(1'b1, 1200, fault_n, n);
        check("pg_resume", fault_n, 1'b1);
        // one saturation entry, one undervoltage, one power-good loss; restarts do not count
        apb(1'b0, FAULT_COUNT_OFFSET, '0, rd, err);
        check("fault_count", rd, 32'h3);
        $display("test supply faults done");
        complete_run();
    end
endmodule
